//--- hdl/ctmr_defines.svh
// Behaviour
// - Period code picks 128 to 1024 counts
// - Period match only on 128-count multiples
// - Period code zero clears by overflow
// - Mode field selects compare, PWM, timer
// - Compare mode applies pin action on match
// - PWM mode forces inactive, active, or waveform
// - Match requesting initial level shows no change
// - Timer on rise restores initial level
// - Initial level sets pre-match or active level
// - Invert bit flips the output pin in compare and PWM modes
// - Swap bit exchanges period and duty roles
// - Clear select picks match A or period
// - PWM ignores clear select
// - Counter readable as low and high bytes
// - Counter upper bits zero, writes ignored
// - Match A low byte read write, resets zero
// - Low bytes pass through shared low-byte buffer
// - Timer on rise clears, fall holds count
// - Match A compares all ten bits
// - Duty at or above period gives full duty
`ifndef CTMR_DEFINES_SVH
`define CTMR_DEFINES_SVH
`define CTMR_OFF_CTRL0    12'h000
`define CTMR_OFF_CTRL1    12'h004
`define CTMR_OFF_CNT_LO   12'h008
`define CTMR_OFF_CNT_HI   12'h00C
`define CTMR_OFF_MA_LO    12'h010
`define CTMR_OFF_MA_HI    12'h014
`define CTMR_C0_ON        3
`define CTMR_C0_PAUSE     7
`define CTMR_RESET_BYTE   8'h00
`define CTMR_CNT_MAX      10'h3FF
`endif

//--- hdl/ctmr_pkg.sv
package ctmr_pkg;
    // Mode codes of the two-bit mode field
    typedef enum logic [1:0]
    {
        CTMR_MODE_CMP  = 2'h0,
        CTMR_MODE_UND  = 2'h1,
        CTMR_MODE_PWM  = 2'h2,
        CTMR_MODE_TMR  = 2'h3
    } ctmr_mode_t;

    // Mode and output control byte
    typedef struct packed
    {
        ctmr_mode_t op_mode_sel;
        logic [1:0] pin_action_sel;
        logic       pin_initial_level;
        logic       pin_invert;
        logic       period_duty_swap;
        logic       clear_select;
    } ctmr_ctrl1_t;

    // APB response carried as one bundle
    typedef struct packed
    {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ctmr_apb_rsp_t;

    // Whole state of the timer
    typedef struct packed
    {
        logic [2:0]    period_compare_bits;
        logic          timer_on;
        logic          pause;
        ctmr_ctrl1_t   ctrl1;
        logic [9:0]    count;
        logic [9:0]    match_a_value;
        logic [7:0]    low_buf;
        logic          pin_level;
        logic          pwm_level;
        logic          pin_out;
        logic          pin_en;
        ctmr_apb_rsp_t rsp;
    } ctmr_state_t;
endpackage : ctmr_pkg

//--- hdl/ctmr_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defines.svh"

module ctmr_timer
    import ctmr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        count_en_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic        pready_o,
    output var  logic [31:0] prdata_o,
    output var  logic        pslverr_o,
    output var  logic        timer_out_o,
    output var  logic        timer_out_en_o
);

    ctmr_state_t st;
    ctmr_state_t next_st;

    logic       tick;
    logic [9:0] nxt_cnt;
    logic       per_match;
    logic       a_match;
    logic       ovf;
    logic       clr;
    logic [9:0] period_cnt;
    logic [9:0] duty_cnt;
    logic       full_duty;
    logic       pwm_on;
    logic       want;
    logic       acc;
    logic [7:0] wbyte;

    // Comparators see the value the next tick would load, so a period
    // of N counts runs 0 to N-1; period matches the top three bits with the low seven zero
    always_comb
    begin
        tick      = count_en_i && st.timer_on && !st.pause;
        nxt_cnt   = st.count + 10'h001;
        per_match = (nxt_cnt[9:7] == st.period_compare_bits)
                    && (nxt_cnt[6:0] == 7'h00)
                    && (st.period_compare_bits != 3'h0);
        ovf       = (st.count == `CTMR_CNT_MAX);
        a_match   = (nxt_cnt == st.match_a_value);
        // Period length in counts; code zero gives 0 here, not 1024
        period_cnt = {st.period_compare_bits, 7'h00};
        duty_cnt   = st.match_a_value;
        if (st.ctrl1.period_duty_swap)
        begin
            period_cnt = st.match_a_value;
            duty_cnt   = {st.period_compare_bits, 7'h00};
        end
        full_duty = (st.ctrl1.period_duty_swap
                     ? st.period_compare_bits == 3'h0
                     : 1'b0)
                    || (period_cnt != 10'h000
                        && duty_cnt >= period_cnt);
        if (st.ctrl1.op_mode_sel == CTMR_MODE_PWM)
        begin
            // Swap picks the clearing comparator; clear bit ignored
            if (st.ctrl1.period_duty_swap)
                clr = a_match;
            else
                clr = per_match || (st.period_compare_bits == 3'h0 && ovf);
        end
        else if (st.ctrl1.clear_select)
            clr = a_match;
        else
            clr = per_match || (st.period_compare_bits == 3'h0 && ovf);
    end

    // Register access strobe and written byte
    always_comb
    begin
        acc   = psel_i && penable_i && !st.rsp.pready;
        wbyte = pwdata_i[7:0];
    end

    // Next state
    always_comb
    begin
        next_st             = st;
        next_st.rsp.pready  = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        // Counter: clear wins over increment
        if (tick)
        begin
            if (clr)
                next_st.count = 10'h000;
            else
                next_st.count = st.count + 10'h001;
        end
        // Compare output action on match A
        if (tick && a_match && st.ctrl1.op_mode_sel == CTMR_MODE_CMP)
        begin
            unique case (st.ctrl1.pin_action_sel)
                2'h0: next_st.pin_level = st.pin_level;
                2'h1: next_st.pin_level = 1'b0;
                2'h2: next_st.pin_level = 1'b1;
                2'h3: next_st.pin_level = !st.pin_level;
            endcase
        end
        // PWM waveform: active until duty count reached
        pwm_on = full_duty || (st.count < duty_cnt);
        next_st.pwm_level = pwm_on;
        // Bus transfer, one wait state on every access
        if (acc)
        begin
            next_st.rsp.pready = 1'b1;
            next_st.rsp.prdata = 32'h0000_0000;
            unique case (paddr_i)
                `CTMR_OFF_CTRL0:
                begin
                    if (pwrite_i)
                    begin
                        next_st.timer_on = wbyte[`CTMR_C0_ON];
                        next_st.pause    = wbyte[`CTMR_C0_PAUSE];
                        next_st.period_compare_bits = wbyte[2:0];
                        // Rising on: clear count, restore level
                        if (wbyte[`CTMR_C0_ON] && !st.timer_on)
                        begin
                            next_st.count     = 10'h000;
                            next_st.pin_level =
                                st.ctrl1.pin_initial_level;
                        end
                    end
                    else
                        next_st.rsp.prdata[7:0] = {st.pause, 3'h0,
                            st.timer_on, st.period_compare_bits};
                end
                `CTMR_OFF_CTRL1:
                begin
                    if (pwrite_i)
                        next_st.ctrl1 = ctmr_ctrl1_t'(wbyte);
                    else
                        next_st.rsp.prdata[7:0] = st.ctrl1;
                end
                `CTMR_OFF_CNT_LO:
                begin
                    if (!pwrite_i)
                        next_st.rsp.prdata[7:0] = st.low_buf;
                end
                `CTMR_OFF_CNT_HI:
                begin
                    // Writes ignored; read latches low byte
                    if (!pwrite_i)
                    begin
                        next_st.rsp.prdata[1:0] = st.count[9:8];
                        next_st.low_buf = st.count[7:0];
                    end
                end
                `CTMR_OFF_MA_LO:
                begin
                    if (pwrite_i)
                        next_st.low_buf = wbyte;
                    else
                        next_st.rsp.prdata[7:0] = st.low_buf;
                end
                `CTMR_OFF_MA_HI:
                begin
                    if (pwrite_i)
                        next_st.match_a_value = {wbyte[1:0],
                                                 st.low_buf};
                    else
                    begin
                        next_st.rsp.prdata[1:0] = st.match_a_value[9:8];
                        next_st.low_buf = st.match_a_value[7:0];
                    end
                end
                default:
                    next_st.rsp.pslverr = 1'b1;
            endcase
        end
        // Pin level by mode; invert last, not in timer or undefined mode
        unique case (st.ctrl1.op_mode_sel)
            CTMR_MODE_PWM:
            begin
                unique case (st.ctrl1.pin_action_sel)
                    2'h0: want = !st.ctrl1.pin_initial_level;
                    2'h1: want = st.ctrl1.pin_initial_level;
                    2'h2: want = st.pwm_level
                                 ~^ st.ctrl1.pin_initial_level;
                    default: want = !st.ctrl1.pin_initial_level;
                endcase
            end
            CTMR_MODE_CMP: want = st.pin_level;
            default:       want = 1'b0;
        endcase
        if (st.ctrl1.op_mode_sel != CTMR_MODE_TMR
            && st.ctrl1.op_mode_sel != CTMR_MODE_UND)
            next_st.pin_out = want ^ st.ctrl1.pin_invert;
        else
            next_st.pin_out = 1'b0;
        // Pin enable registered so the port comes from a flop
        next_st.pin_en = next_st.timer_on
                         && next_st.ctrl1.op_mode_sel != CTMR_MODE_TMR;
        if (reset_i)
            next_st = '0;
    end

    // Single state register
    always_ff @(posedge clk_i)
    begin
        st <= next_st;
    end

    // Outputs straight from flops
    always_comb
    begin
        pready_o       = st.rsp.pready;
        prdata_o       = st.rsp.prdata;
        pslverr_o      = st.rsp.pslverr;
        timer_out_o    = st.pin_out;
        timer_out_en_o = st.pin_en;
    end

    // Checks
    sequence s_rise_on;
        acc && pwrite_i && paddr_i == `CTMR_OFF_CTRL0
        && pwdata_i[`CTMR_C0_ON] && !st.timer_on;
    endsequence

    chk_rise_clears: assert property (@(posedge clk_i) disable iff (reset_i)
        s_rise_on |=> st.count == 10'h000)
        else $error("Counter not cleared on timer on rise");
    chk_clear_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        tick && clr && !acc |=> st.count == 10'h000)
        else $error("Clear did not load zero");
    chk_hold_off: assert property (@(posedge clk_i) disable iff (reset_i)
        !st.timer_on && !acc |=> $stable(st.count))
        else $error("Counter moved while off");
    chk_period_step: assert property (@(posedge clk_i) disable iff (reset_i)
        per_match |-> st.count[6:0] == 7'h7F)
        else $error("Period match off 128 boundary");
    chk_cnt_hi_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        acc && !pwrite_i && paddr_i == `CTMR_OFF_CNT_HI
        |=> prdata_o[31:2] == 30'h0)
        else $error("Counter high upper bits not zero");
    chk_ma_commit: assert property (@(posedge clk_i) disable iff (reset_i)
        acc && pwrite_i && paddr_i == `CTMR_OFF_MA_HI
        |=> st.match_a_value[7:0] == $past(st.low_buf))
        else $error("High write did not commit buffer");
    chk_init_level: assert property (@(posedge clk_i) disable iff (reset_i)
        s_rise_on |=> st.pin_level == $past(st.ctrl1.pin_initial_level))
        else $error("Initial level not restored");
    chk_cmp_set: assert property (@(posedge clk_i) disable iff (reset_i)
        tick && a_match && !acc && st.ctrl1.op_mode_sel == CTMR_MODE_CMP
        && st.ctrl1.pin_action_sel == 2'h2 |=> st.pin_level)
        else $error("Compare output high action failed");
    chk_pwm_full: assert property (@(posedge clk_i) disable iff (reset_i)
        full_duty |=> st.pwm_level)
        else $error("Full duty not active");
    chk_tmr_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_TMR ##1
        st.ctrl1.op_mode_sel == CTMR_MODE_TMR |-> !timer_out_o)
        else $error("Output active in timer mode");

    // Shared steps: a tick with no bus override, a compare hit
    sequence s_free_tick;
        tick && !acc;
    endsequence
    sequence s_cmp_hit;
        tick && a_match && !acc
        && st.ctrl1.op_mode_sel == CTMR_MODE_CMP;
    endsequence

    // Counter steps and clear sources
    chk_cnt_step: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 !clr
        |=> st.count == $past(st.count) + 10'h001)
        else $error("Counter did not step by one");
    chk_wrap_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 (ovf && st.period_compare_bits == 3'h0)
        |=> st.count == 10'h000)
        else $error("Overflow did not clear counter");
    chk_per_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 (per_match && !st.ctrl1.clear_select
        && st.ctrl1.op_mode_sel != CTMR_MODE_PWM)
        |=> st.count == 10'h000)
        else $error("Period match did not clear counter");
    chk_a_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 (a_match && st.ctrl1.clear_select
        && st.ctrl1.op_mode_sel != CTMR_MODE_PWM)
        |=> st.count == 10'h000)
        else $error("Match A did not clear counter");
    chk_pwm_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 (st.ctrl1.op_mode_sel == CTMR_MODE_PWM
        && (st.ctrl1.period_duty_swap ? a_match : per_match))
        |=> st.count == 10'h000)
        else $error("PWM clear source wrong");
    chk_pwm_nosel: assert property (@(posedge clk_i) disable iff (reset_i)
        s_free_tick ##0 (st.ctrl1.op_mode_sel == CTMR_MODE_PWM
        && !st.ctrl1.period_duty_swap && a_match && !per_match)
        |=> st.count == $past(st.count) + 10'h001)
        else $error("PWM cleared on match A without swap");

    // Compare mode pin actions and output polarity
    chk_cmp_low: assert property (@(posedge clk_i) disable iff (reset_i)
        s_cmp_hit ##0 st.ctrl1.pin_action_sel == 2'h1
        |=> !st.pin_level)
        else $error("Compare output low action failed");
    chk_cmp_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
        s_cmp_hit ##0 st.ctrl1.pin_action_sel == 2'h3
        |=> st.pin_level == !$past(st.pin_level))
        else $error("Compare output toggle failed");
    chk_cmp_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        s_cmp_hit ##0 st.ctrl1.pin_action_sel == 2'h0
        |=> $stable(st.pin_level))
        else $error("Compare output changed on no action");
    chk_cmp_pin: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_CMP
        |=> timer_out_o == ($past(st.pin_level)
                            ^ $past(st.ctrl1.pin_invert)))
        else $error("Compare pin level or invert wrong");

    // PWM forcing, waveform; undefined mode stays low
    chk_pwm_off: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_PWM
        && st.ctrl1.pin_action_sel == 2'h0
        |=> timer_out_o == (!$past(st.ctrl1.pin_initial_level)
                            ^ $past(st.ctrl1.pin_invert)))
        else $error("PWM inactive force failed");
    chk_pwm_on: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_PWM
        && st.ctrl1.pin_action_sel == 2'h1
        |=> timer_out_o == ($past(st.ctrl1.pin_initial_level)
                            ^ $past(st.ctrl1.pin_invert)))
        else $error("PWM active force failed");
    chk_pwm_wave: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_PWM
        && st.ctrl1.pin_action_sel == 2'h2
        |=> timer_out_o == (($past(st.pwm_level)
                             ~^ $past(st.ctrl1.pin_initial_level))
                            ^ $past(st.ctrl1.pin_invert)))
        else $error("PWM waveform polarity wrong");
    chk_pwm_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        !full_duty && st.count >= duty_cnt |=> !st.pwm_level)
        else $error("PWM active past duty");
    chk_undef_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        st.ctrl1.op_mode_sel == CTMR_MODE_UND |=> !timer_out_o)
        else $error("Output active in undefined mode");

    // Byte access through the shared low byte buffer
    chk_cnt_lo_rd: assert property (@(posedge clk_i) disable iff (reset_i)
        acc && !pwrite_i && paddr_i == `CTMR_OFF_CNT_LO
        |=> prdata_o == {24'h00_0000, $past(st.low_buf)})
        else $error("Counter low read not from buffer");
    chk_ma_lo_buf: assert property (@(posedge clk_i) disable iff (reset_i)
        acc && pwrite_i && paddr_i == `CTMR_OFF_MA_LO
        |=> st.low_buf == $past(pwdata_i[7:0])
            && $stable(st.match_a_value))
        else $error("Low write not held in buffer");

endmodule : ctmr_timer
`default_nettype wire

//--- verification/compact_timer_mode_output_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctmr_defines.svh"

module compact_timer_mode_output_control_test
    import ctmr_pkg::*;
;
    logic        clk_i      = 1'b0;
    logic        reset_i    = 1'b1;
    logic        count_en_i = 1'b0;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [11:0] paddr_i    = 12'h000;
    logic [31:0] pwdata_i   = 32'h0000_0000;
    logic        pready_o;
    logic [31:0] prdata_o;
    logic        pslverr_o;
    logic        timer_out_o;
    logic        timer_out_en_o;
    logic [31:0] rd_q;
    logic        slv;
    int          mismatches = 0;
    int          num_checks = 0;

    ctmr_timer dut_u
    (
        .clk_i          (clk_i),
        .reset_i        (reset_i),
        .count_en_i     (count_en_i),
        .psel_i         (psel_i),
        .penable_i      (penable_i),
        .pwrite_i       (pwrite_i),
        .paddr_i        (paddr_i),
        .pwdata_i       (pwdata_i),
        .pready_o       (pready_o),
        .prdata_o       (prdata_o),
        .pslverr_o      (pslverr_o),
        .timer_out_o    (timer_out_o),
        .timer_out_en_o (timer_out_en_o)
    );

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: byte got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    // One APB transfer; an edge first keeps release and setup apart
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= {24'h00_0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        r = prdata_o;
        slv = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rd_q);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, rd_q);
        chk_byte(rd_q[7:0], exp);
    endtask : rdc

    // High byte first so the buffer holds the matching low byte
    task automatic rdcnt(input logic [9:0] e);
        rdc(`CTMR_OFF_CNT_HI, {6'h00, e[9:8]});
        rdc(`CTMR_OFF_CNT_LO, e[7:0]);
    endtask : rdcnt

    // Count pulses two cycles apart, then let the pin settle
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            count_en_i <= 1'b1;
            @(posedge clk_i);
            count_en_i <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
    endtask : tick

    // Stop, configure, restart from zero, count
    task automatic run(input logic [7:0] c1, input logic [7:0] c0,
                       input int n);
        wr(`CTMR_OFF_CTRL0, 8'h00);
        wr(`CTMR_OFF_CTRL1, c1);
        wr(`CTMR_OFF_CTRL0, c0);
        tick(n);
    endtask : run

    task automatic t_regs();
        rdc(`CTMR_OFF_CTRL1, 8'h00);
        rdcnt(10'h000);
        rdc(`CTMR_OFF_MA_HI, 8'h00);
        rdc(`CTMR_OFF_MA_LO, 8'h00);
        wr(`CTMR_OFF_CNT_LO, 8'hFF);
        chk_bit(slv, 1'b0);
        rdcnt(10'h000);
        wr(`CTMR_OFF_CTRL1, 8'hA5);
        rdc(`CTMR_OFF_CTRL1, 8'hA5);
        apb(1'b0, 12'h020, 8'h00, rd_q);
        chk_bit(slv, 1'b1);
    endtask : t_regs

    task automatic t_count();
        run(8'hC0, 8'h08, 300);
        chk_bit(timer_out_en_o, 1'b0);
        wr(`CTMR_OFF_CTRL0, 8'h00);
        tick(5);
        rdcnt(10'h12C);
        wr(`CTMR_OFF_CTRL0, 8'h08);
        wr(`CTMR_OFF_CTRL0, 8'h00);
        rdcnt(10'h000);
        // Undefined mode with initial level high keeps the pin low
        run(8'h48, 8'h08, 0);
        chk_bit(timer_out_o, 1'b0);
    endtask : t_count

    // Period match clears; a cycle holds code*128 counts, 1024 for code zero
    task automatic t_period(input logic [2:0] code, input int n);
        int p;
        p = (code == 3'h0) ? 1024 : code * 128;
        run(8'hC0, {5'h01, code}, n);
        rdcnt(10'(n % p));
    endtask : t_period

    task automatic t_match_a();
        wr(`CTMR_OFF_MA_LO, 8'h05);
        wr(`CTMR_OFF_MA_HI, 8'h01);
        rdc(`CTMR_OFF_MA_HI, 8'h01);
        rdc(`CTMR_OFF_MA_LO, 8'h05);
        run(8'hC1, 8'h09, 300);
        rdcnt(10'(300 % 261));
    endtask : t_match_a

    // Compare mode pin action for every code, level and polarity
    task automatic t_pin();
        logic e;
        wr(`CTMR_OFF_MA_LO, 8'h04);
        wr(`CTMR_OFF_MA_HI, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            run({CTMR_MODE_CMP, k[3:0], 2'h1}, 8'h08, 0);
            chk_bit(timer_out_o, k[1] ^ k[0]);
            chk_bit(timer_out_en_o, 1'b1);
            tick(5);
            e = (k[3:2] == 2'h0) ? k[1] : (k[3:2] == 2'h3) ? ~k[1] : k[3];
            chk_bit(timer_out_o, e ^ k[0]);
            wr(`CTMR_OFF_CTRL0, 8'h00);
            wr(`CTMR_OFF_CTRL0, 8'h08);
            tick(0);
            chk_bit(timer_out_o, k[1] ^ k[0]);
        end
    endtask : t_pin

    // PWM active high, period code 1, clear select set but unused
    task automatic t_pwm(input logic sw, input logic [1:0] act,
                         input logic [7:0] ma, input int n, input logic e);
        wr(`CTMR_OFF_MA_LO, ma);
        wr(`CTMR_OFF_MA_HI, 8'h00);
        run({CTMR_MODE_PWM, act, 2'h2, sw, 1'b1}, 8'h09, n);
        chk_bit(timer_out_o, e);
    endtask : t_pwm

    // Watchdog well beyond the expected run length
    initial
    begin
        #(20 * 60000);
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_count();
        t_period(3'h1, 200);
        t_period(3'h3, 400);
        t_period(3'h0, 1030);
        t_match_a();
        t_pin();
        t_pwm(1'b0, 2'h2, 8'h20, 31, 1'b1);
        t_pwm(1'b0, 2'h2, 8'h20, 40, 1'b0);
        t_pwm(1'b0, 2'h2, 8'hC8, 127, 1'b1);
        t_pwm(1'b1, 2'h2, 8'hC8, 130, 1'b0);
        t_pwm(1'b0, 2'h0, 8'h20, 5, 1'b0);
        t_pwm(1'b0, 2'h1, 8'h20, 40, 1'b1);
        t_pwm(1'b0, 2'h3, 8'h20, 5, 1'b0);
        conclude();
    end
endmodule : compact_timer_mode_output_control_test
`default_nettype wire
